// ==== logic/pmc_pkg.sv ====
// Package of modes, peripheral enable layout and timing counts for the power mode controller.
package pmc_pkg;

  // Device power modes, one-hot.
  typedef enum logic [5:0] {
    PMC_RUN      = 6'h01,
    PMC_VLP_RUN  = 6'h02,
    PMC_WAIT     = 6'h04,
    PMC_VLP_WAIT = 6'h08,
    PMC_STOP     = 6'h10,
    PMC_VLP_STOP = 6'h20
  } pmc_mode_e;

  // Controller sequencing states, one-hot.
  typedef enum logic [3:0] {
    PMC_ST_IDLE   = 4'h1,
    PMC_ST_SLEEP  = 4'h2,
    PMC_ST_WAKE   = 4'h4,
    PMC_ST_RESUME = 4'h8
  } pmc_state_e;

  // Peripheral clock enable vector bit positions.
  localparam int PMC_PB_ADC          = 0;
  localparam int PMC_PB_COMPARATOR   = 1;
  localparam int PMC_PB_TICK_TMR     = 2;
  localparam int PMC_PB_RTC          = 3;
  localparam int PMC_PB_PORT         = 4;
  localparam int PMC_PB_XTAL         = 5;
  localparam int PMC_PB_PERIODIC_TMR = 6;
  localparam int PMC_PB_PROG_IO      = 7;
  localparam int PMC_PB_SERIAL       = 8;
  localparam int PMC_PB_DMA          = 9;
  localparam int PMC_PB_OTHER        = 10;
  localparam int PMC_PERIPH_W        = 11;

  // Peripheral sets kept clocked in run and wait, and in each stop-class mode.
  localparam logic [10:0] PMC_PERIPH_ALL      = 11'h7ff;
  localparam logic [10:0] PMC_PERIPH_STOP     = 11'h01f;
  localparam logic [10:0] PMC_PERIPH_VLP_STOP = 11'h3ef;

  // Clock settle time before the core is released, and its cycle count at 50 MHz.
  localparam int PMC_CLK_MHZ         = 50;
  localparam int PMC_SETTLE_NS       = 100;
  localparam int PMC_SETTLE_CYC      = (PMC_SETTLE_NS * PMC_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] PMC_SETTLE_CNT = 8'(PMC_SETTLE_CYC);

  // Low-power configuration from the system mode controller.
  typedef struct packed {
    logic deep_sleep;   // Sleep request selects stop class when set.
    logic vlp_select;      // Very low power variant of stop.
    logic vlp_run_request; // Run in very low power run.
  } pmc_cfg_s;

  // Control outputs to clocks, core and monitors.
  typedef struct packed {
    pmc_mode_e           mode;
    logic                core_clk_en;
    logic                reduced_freq;
    logic                low_voltage_monitor_en;
    logic                nested_vector_irq_clk_en;
    logic                async_wake_irq_en;
    logic                sram_retain;
    logic                reg_retain;
    logic [10:0]         periph_clk_en;
  } pmc_ctrl_s;

  // Mode decode used by the controller and its assertion checker.
  function automatic logic pmc_is_stop(input pmc_mode_e m);
    return (m == PMC_STOP) || (m == PMC_VLP_STOP);
  endfunction

endpackage

// ==== logic/pmc_power_mode_ctrl.sv ====
// Power mode controller that maps core sleep requests onto the six device modes.
// Overview of operation
// - A sleep instruction enters wait-class or stop-class mode per configuration.
// - Both run modes keep the core active with all peripherals.
// - Normal run keeps every module at full clocking.
// - Very low power run reduces clocks and disables the voltage monitor.
// - Wait sleeps the core with all peripherals enabled.
// - Very low power wait sleeps core, reduces clocks, voltage monitor off.
// - Wait-class modes wake through the nested interrupt controller.
// - Stop-class modes wake through the asynchronous wake controller.
// - Stop gates most peripheral clocks leaving them static.
// - Stop retains registers and SRAM with voltage monitor active.
// - Stop keeps converter, comparator, tick timer, clock, pin interrupts running.
// - Very low power stop retains SRAM and keeps listed peripherals running.
// - Very low power stop disables voltage monitor and nested controller.
// - Asynchronous wake restarts clocks before nested controller handles interrupt.
// - Any enabled pin interrupt wakes from stop-class modes.
`timescale 1ns/10ps
module pmc_power_mode_ctrl
  import pmc_pkg::*;
#(
  parameter int PIN_W = 8
) (
  // Clock and reset.
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  // Core sleep request and configuration.
  input  wire logic             wait_for_interrupt_instr,
  input  wire logic             wait_for_event_instr,
  input  wire pmc_cfg_s         cfg,
  // Wake sources.
  input  wire logic             nested_vector_irq_pending,
  input  wire logic [PIN_W-1:0] pin_irq,
  input  wire logic [PIN_W-1:0] pin_irq_en,
  input  wire logic             periph_wake,
  // Control outputs.
  output pmc_ctrl_s             ctrl_q,
  output logic                  wake_req_q,
  output logic                  busy_q
);

  // Sequencer state: the step of the sleep and wake sequence, the run mode to
  // return to, the control word shown on the outputs, the settle counter, the
  // wake strobe towards clock control and the registered busy flag.
  typedef struct packed {
    pmc_state_e state;
    pmc_mode_e  run_mode;
    pmc_ctrl_s  ctrl;
    logic [7:0] cnt;
    logic       wake_req;
    logic       busy;
  } pmc_top_s;

  // Registered state and its next value.
  pmc_top_s s_q;
  pmc_top_s s_d;

  // Wake detector hand-over.
  logic     async_wake;
  logic     wake_armed;

  // Control word for a given mode. Every field is written in every branch so
  // that the meaning of each mode reads off one place, and so that no field
  // silently keeps the value that a neighbouring mode happens to need.
  function automatic pmc_ctrl_s mode_ctrl(input pmc_mode_e m);
    pmc_ctrl_s c;
    c = '0;
    unique case (m)
      // Normal run: core clocked at full speed, every module clocked.
      PMC_RUN: begin
        c.mode                     = PMC_RUN;
        c.core_clk_en              = 1'b1;
        c.reduced_freq             = 1'b0;
        c.low_voltage_monitor_en   = 1'b1;
        c.nested_vector_irq_clk_en = 1'b1;
        c.async_wake_irq_en        = 1'b0;
        c.sram_retain              = 1'b1;
        c.reg_retain               = 1'b1;
        c.periph_clk_en            = PMC_PERIPH_ALL;
      end
      // Very low power run: core and modules on the reduced clock, monitor off.
      PMC_VLP_RUN: begin
        c.mode                     = PMC_VLP_RUN;
        c.core_clk_en              = 1'b1;
        c.reduced_freq             = 1'b1;
        c.low_voltage_monitor_en   = 1'b0;
        c.nested_vector_irq_clk_en = 1'b1;
        c.async_wake_irq_en        = 1'b0;
        c.sram_retain              = 1'b1;
        c.reg_retain               = 1'b1;
        c.periph_clk_en            = PMC_PERIPH_ALL;
      end
      // Wait: core asleep, every peripheral still clocked as programmed.
      PMC_WAIT: begin
        c.mode                     = PMC_WAIT;
        c.core_clk_en              = 1'b0;
        c.reduced_freq             = 1'b0;
        c.low_voltage_monitor_en   = 1'b1;
        c.nested_vector_irq_clk_en = 1'b1;
        c.async_wake_irq_en        = 1'b0;
        c.sram_retain              = 1'b1;
        c.reg_retain               = 1'b1;
        c.periph_clk_en            = PMC_PERIPH_ALL;
      end
      // Very low power wait: core asleep, reduced clock, monitor off.
      PMC_VLP_WAIT: begin
        c.mode                     = PMC_VLP_WAIT;
        c.core_clk_en              = 1'b0;
        c.reduced_freq             = 1'b1;
        c.low_voltage_monitor_en   = 1'b0;
        c.nested_vector_irq_clk_en = 1'b1;
        c.async_wake_irq_en        = 1'b0;
        c.sram_retain              = 1'b1;
        c.reg_retain               = 1'b1;
        c.periph_clk_en            = PMC_PERIPH_ALL;
      end
      // Stop: most clocks gated, everything retained, monitor kept on.
      PMC_STOP: begin
        c.mode                     = PMC_STOP;
        c.core_clk_en              = 1'b0;
        c.reduced_freq             = 1'b0;
        c.low_voltage_monitor_en   = 1'b1;
        c.nested_vector_irq_clk_en = 1'b0;
        c.async_wake_irq_en        = 1'b1;
        c.sram_retain              = 1'b1;
        c.reg_retain               = 1'b1;
        c.periph_clk_en            = PMC_PERIPH_STOP;
      end
      // Very low power stop: only memory kept, a wider set of wake-capable
      // peripherals stays clocked, monitor and nested controller are off.
      PMC_VLP_STOP: begin
        c.mode                     = PMC_VLP_STOP;
        c.core_clk_en              = 1'b0;
        c.reduced_freq             = 1'b0;
        c.low_voltage_monitor_en   = 1'b0;
        c.nested_vector_irq_clk_en = 1'b0;
        c.async_wake_irq_en        = 1'b1;
        c.sram_retain              = 1'b1;
        c.reg_retain               = 1'b0;
        c.periph_clk_en            = PMC_PERIPH_VLP_STOP;
      end
      // An illegal mode code falls back to the safe, fully clocked run word.
      default: begin
        c.mode                     = PMC_RUN;
        c.core_clk_en              = 1'b1;
        c.reduced_freq             = 1'b0;
        c.low_voltage_monitor_en   = 1'b1;
        c.nested_vector_irq_clk_en = 1'b1;
        c.async_wake_irq_en        = 1'b0;
        c.sram_retain              = 1'b1;
        c.reg_retain               = 1'b1;
        c.periph_clk_en            = PMC_PERIPH_ALL;
      end
    endcase
    return c;
  endfunction

  // Control word while clocks come back after a wake: the run-mode clocks are
  // restored first and the core stays off until the sequence reaches idle,
  // so the core never runs on a clock that is still settling.
  function automatic pmc_ctrl_s resume_ctrl(input pmc_mode_e m);
    pmc_ctrl_s c;
    c             = mode_ctrl(m);
    c.core_clk_en = 1'b0;
    return c;
  endfunction

  // Sleep mode for a request: stop class when deep sleep is set, otherwise
  // the wait-class mode that matches the run mode in force.
  function automatic pmc_mode_e sleep_mode(input pmc_cfg_s c, input pmc_mode_e run);
    pmc_mode_e m;
    if (c.deep_sleep) begin
      m = c.vlp_select ? PMC_VLP_STOP : PMC_STOP;
    end else begin
      m = (run == PMC_VLP_RUN) ? PMC_VLP_WAIT : PMC_WAIT;
    end
    return m;
  endfunction

  // The detector listens only while a stop-class sleep is in force, so that a
  // pin event seen in run or wait cannot leave a stale wake behind.
  assign wake_armed = (s_q.state == PMC_ST_SLEEP) && pmc_is_stop(s_q.ctrl.mode);

  // Stop-class wake detector; it needs no clock gating of its own because it
  // sits on the free-running controller clock.
  pmc_wake_detect #(
    .PIN_W (PIN_W)
  ) u_wake (
    .ref_clk     (ref_clk),
    .nrst        (nrst),
    .pin_irq     (pin_irq),
    .pin_irq_en  (pin_irq_en),
    .periph_wake (periph_wake),
    .armed       (wake_armed),
    .wake_q      (async_wake)
  );

  // Next-state logic for mode sequencing. A request is only taken in idle;
  // once the sequence has left idle, further sleep instructions are dropped
  // without trace until the return to run has completed.
  always_comb begin
    s_d          = s_q;
    s_d.wake_req = 1'b0;
    unique case (s_q.state)
      // Idle: follow the run-mode request and take a sleep instruction.
      PMC_ST_IDLE: begin
        s_d.run_mode = cfg.vlp_run_request ? PMC_VLP_RUN : PMC_RUN;
        s_d.ctrl     = mode_ctrl(s_d.run_mode);
        if (wait_for_interrupt_instr || wait_for_event_instr) begin
          s_d.state = PMC_ST_SLEEP;
          s_d.ctrl  = mode_ctrl(sleep_mode(cfg, s_d.run_mode));
        end
      end
      // Sleep: wait-class modes leave on a pending nested interrupt, while
      // stop-class modes leave only through the asynchronous detector, as the
      // nested controller has no clock there.
      PMC_ST_SLEEP: begin
        if (pmc_is_stop(s_q.ctrl.mode)) begin
          if (async_wake) begin
            s_d.state    = PMC_ST_WAKE;
            s_d.wake_req = 1'b1;
            s_d.ctrl     = resume_ctrl(s_q.run_mode);
            s_d.cnt      = PMC_SETTLE_CNT;
          end
        end else if (nested_vector_irq_pending) begin
          s_d.state = PMC_ST_RESUME;
          s_d.ctrl  = resume_ctrl(s_q.run_mode);
        end
      end
      // Wake: clocks are back on, count out the settle time.
      PMC_ST_WAKE: begin
        if (s_q.cnt <= 8'h01) begin
          s_d.state = PMC_ST_RESUME;
        end else begin
          s_d.cnt = s_q.cnt - 8'h01;
        end
      end
      // Resume: release the core into the run mode held from before entry.
      PMC_ST_RESUME: begin
        s_d.state = PMC_ST_IDLE;
        s_d.ctrl  = mode_ctrl(s_q.run_mode);
      end
      // An illegal state code returns to idle in the remembered run mode.
      default: begin
        s_d.state = PMC_ST_IDLE;
        s_d.ctrl  = mode_ctrl(s_q.run_mode);
      end
    endcase
    // Busy follows the next state so that it can leave a flip-flop.
    s_d.busy = (s_d.state != PMC_ST_IDLE);
  end

  // Register the state; reset puts the device in normal run, not busy.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s_q.state    <= PMC_ST_IDLE;
      s_q.run_mode <= PMC_RUN;
      s_q.ctrl     <= '{mode: PMC_RUN, core_clk_en: 1'b1, reduced_freq: 1'b0,
                        low_voltage_monitor_en: 1'b1, nested_vector_irq_clk_en: 1'b1,
                        async_wake_irq_en: 1'b0, sram_retain: 1'b1, reg_retain: 1'b1,
                        periph_clk_en: PMC_PERIPH_ALL};
      s_q.cnt      <= 8'h00;
      s_q.wake_req <= 1'b0;
      s_q.busy     <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops.
  assign ctrl_q     = s_q.ctrl;
  assign wake_req_q = s_q.wake_req;
  assign busy_q     = s_q.busy;

endmodule

// ==== logic/pmc_wake_detect.sv ====
// Asynchronous-path wake detector that gathers enabled pin and peripheral wake events.
`timescale 1ns/10ps
module pmc_wake_detect
  import pmc_pkg::*;
#(
  parameter int PIN_W = 8
) (
  // Clock and reset.
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  // Wake sources.
  input  wire logic [PIN_W-1:0] pin_irq,
  input  wire logic [PIN_W-1:0] pin_irq_en,
  input  wire logic             periph_wake,
  input  wire logic             armed,
  // Result.
  output logic                  wake_q
);

  typedef struct packed {
    logic wake;
  } pmc_wd_s;

  pmc_wd_s s_q;
  pmc_wd_s s_d;

  // Latch any enabled pin interrupt or peripheral wake while armed.
  always_comb begin
    s_d = s_q;
    if (!armed) begin
      s_d.wake = 1'b0;
    end else if (|(pin_irq & pin_irq_en) || periph_wake) begin
      s_d.wake = 1'b1;
    end
  end

  // Register the state.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wake_q = s_q.wake;

endmodule

// ==== verif/pmc_assertions.sv ====
// Checker of mode outputs, wake paths and sleep entry timing.
`timescale 1ns/10ps
module pmc_assertions import pmc_pkg::*; #(parameter int PIN_W = 8) (
  // Clock and reset.
  input wire logic             ref_clk,
  input wire logic             nrst,
  // Watched ports.
  input wire logic             wait_for_interrupt_instr,
  input wire logic             wait_for_event_instr,
  input wire pmc_cfg_s         cfg,
  input wire logic             nested_vector_irq_pending,
  input wire logic [PIN_W-1:0] pin_irq,
  input wire logic [PIN_W-1:0] pin_irq_en,
  input wire logic             periph_wake,
  input wire pmc_ctrl_s        ctrl_q,
  input wire logic             wake_req_q,
  input wire logic             busy_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // A fresh wake source seen in a stop-class mode, and the strobe it must cause.
  sequence s_stop_wake;
    pmc_is_stop(ctrl_q.mode) && $rose(|(pin_irq & pin_irq_en) || periph_wake);
  endsequence
  sequence s_wake_strobe;
    wake_req_q && !ctrl_q.core_clk_en ##1 !wake_req_q;
  endsequence
  a_sleep_entry: assert property (!busy_q && (wait_for_interrupt_instr || wait_for_event_instr)
    |=> busy_q && !ctrl_q.core_clk_en) else $error("sleep not entered");
  a_run_full: assert property (ctrl_q.mode == PMC_RUN && ctrl_q.core_clk_en |->
    ctrl_q.periph_clk_en == PMC_PERIPH_ALL && !ctrl_q.reduced_freq) else $error("run");
  a_slow_run: assert property (ctrl_q.mode == PMC_VLP_RUN |->
    ctrl_q.reduced_freq && !ctrl_q.low_voltage_monitor_en) else $error("slow run");
  a_wait_mode: assert property (ctrl_q.mode == PMC_WAIT |-> !ctrl_q.core_clk_en &&
    ctrl_q.nested_vector_irq_clk_en && ctrl_q.periph_clk_en == PMC_PERIPH_ALL)
    else $error("wait");
  a_slow_wait: assert property (ctrl_q.mode == PMC_VLP_WAIT |-> !ctrl_q.core_clk_en &&
    ctrl_q.reduced_freq && !ctrl_q.low_voltage_monitor_en) else $error("slow wait");
  a_stop_mode: assert property (ctrl_q.mode == PMC_STOP |->
    ctrl_q.periph_clk_en == PMC_PERIPH_STOP && ctrl_q.low_voltage_monitor_en &&
    ctrl_q.reg_retain && !ctrl_q.nested_vector_irq_clk_en && ctrl_q.async_wake_irq_en)
    else $error("stop");
  a_slow_stop: assert property (ctrl_q.mode == PMC_VLP_STOP |->
    ctrl_q.periph_clk_en == PMC_PERIPH_VLP_STOP && !ctrl_q.low_voltage_monitor_en &&
    ctrl_q.sram_retain && !ctrl_q.nested_vector_irq_clk_en && ctrl_q.async_wake_irq_en)
    else $error("slow stop");
  a_nested_wake: assert property (ctrl_q.mode inside {PMC_WAIT, PMC_VLP_WAIT} &&
    nested_vector_irq_pending |-> ##[1:3] ctrl_q.core_clk_en)
    else $error("no wait wake");
  a_pin_wake: assert property (s_stop_wake |-> ##[1:4] s_wake_strobe)
    else $error("no stop wake");
endmodule

bind pmc_power_mode_ctrl pmc_assertions #(.PIN_W(PIN_W)) u_chk (.ref_clk(ref_clk),
  .nrst(nrst), .wait_for_interrupt_instr(wait_for_interrupt_instr),
  .wait_for_event_instr(wait_for_event_instr), .cfg(cfg),
  .nested_vector_irq_pending(nested_vector_irq_pending),
  .pin_irq(pin_irq), .pin_irq_en(pin_irq_en), .periph_wake(periph_wake), .ctrl_q(ctrl_q),
  .wake_req_q(wake_req_q), .busy_q(busy_q));

// ==== verif/pmc_core_model.sv ====
// Model of the core and nested controller that sleep and raise wake pending.
`timescale 1ns/10ps
module pmc_core_model import pmc_pkg::*; (
  // Clock and bench commands.
  input wire logic ref_clk,
  input wire logic sleep_cmd,
  input wire logic use_event,
  input wire logic slow,
  // Controller side.
  input wire pmc_ctrl_s ctrl_q,
  output logic sleep_intr = 1'b0,
  output logic sleep_evt = 1'b0,
  output logic irq_pend = 1'b0
);
  logic [3:0] cnt_q = 4'h0;
  // Pending rises only while the nested controller is clocked and the core sleeps.
  always @(posedge ref_clk) begin
    sleep_intr <= sleep_cmd & ~use_event;
    sleep_evt <= sleep_cmd & use_event;
    cnt_q <= ctrl_q.core_clk_en ? 4'h0 : cnt_q + 4'h1;
    irq_pend <= ctrl_q.nested_vector_irq_clk_en & ~ctrl_q.core_clk_en &
                (cnt_q >= (slow ? 4'h6 : 4'h1));
  end
endmodule

// ==== verif/pmc_tb.sv ====
// Testbench of the power mode controller with a core model.
`timescale 1ns/10ps
module testbench import pmc_pkg::*; ;
  logic ref_clk = 0, nrst = 0, cmd = 0, evt = 0, slow = 0, pw = 0;
  logic [7:0] pin = 8'h00, pen = 8'h00;
  pmc_cfg_s cfg = '0;
  logic slp_i, slp_e, irqp, wreq, busy;
  pmc_ctrl_s ctrl;
  int fail_count = 0, checks = 0, cyc = 0;
  // Design and its core partner.
  pmc_power_mode_ctrl #(.PIN_W(8)) u_dut (.ref_clk(ref_clk), .nrst(nrst),
    .wait_for_interrupt_instr(slp_i), .wait_for_event_instr(slp_e), .cfg(cfg),
    .nested_vector_irq_pending(irqp), .pin_irq(pin), .pin_irq_en(pen), .periph_wake(pw),
    .ctrl_q(ctrl), .wake_req_q(wreq), .busy_q(busy));
  pmc_core_model u_core (.ref_clk(ref_clk), .sleep_cmd(cmd), .use_event(evt), .slow(slow),
    .ctrl_q(ctrl), .sleep_intr(slp_i), .sleep_evt(slp_e), .irq_pend(irqp));
  always #10 ref_clk = ~ref_clk;
  task automatic finish_test();
    if (fail_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [23:0] e, logic [23:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic sleep(logic e);
    @(posedge ref_clk);
    cmd <= 1'b1;
    evt <= e;
    @(posedge ref_clk);
    cmd <= 1'b0;
    tick(2);
  endtask
  task automatic wait_idle();
    for (int n = 0; n < 40 && busy !== 1'b0; n++) begin
      tick(1);
    end
    chk("busy", 0, busy);
  endtask
  task automatic t_wait(logic vlp);
    @(posedge ref_clk);
    cfg <= '{1'b0, 1'b0, vlp};
    slow <= vlp;
    tick(2);
    chk("run", vlp ? PMC_VLP_RUN : PMC_RUN, ctrl.mode);
    sleep(vlp);
    chk("sleep", vlp ? PMC_VLP_WAIT : PMC_WAIT, ctrl.mode);
    wait_idle();
    chk("back", vlp ? PMC_VLP_RUN : PMC_RUN, ctrl.mode);
    chk("core", 1, ctrl.core_clk_en);
  endtask
  task automatic t_stop(logic vlp);
    @(posedge ref_clk);
    cfg <= '{1'b1, vlp, 1'b0};
    pen <= 8'h04;
    pin <= 8'h08;
    sleep(1'b0);
    chk("mode", vlp ? PMC_VLP_STOP : PMC_STOP, ctrl.mode);
    chk("per", vlp ? PMC_PERIPH_VLP_STOP : PMC_PERIPH_STOP, ctrl.periph_clk_en);
    chk("volt_mon", !vlp, ctrl.low_voltage_monitor_en);
    chk("nested_clk", 0, ctrl.nested_vector_irq_clk_en);
    sleep(1'b1);
    chk("hold", vlp ? PMC_VLP_STOP : PMC_STOP, ctrl.mode);
    @(posedge ref_clk);
    pw <= vlp;
    pin <= vlp ? 8'h08 : 8'h0c;
    for (int n = 0; n < 8 && wreq !== 1'b1; n++) begin
      tick(1);
    end
    chk("wake", 1, wreq);
    @(posedge ref_clk);
    pw <= 1'b0;
    pin <= 8'h00;
    wait_idle();
    chk("back", PMC_RUN, ctrl.mode);
  endtask
  // Reset, then each scenario in turn.
  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    tick(1);
    chk("reset", {PMC_RUN, 7'h5b, PMC_PERIPH_ALL}, ctrl);
    t_wait(1'b0);
    t_wait(1'b1);
    t_stop(1'b0);
    t_stop(1'b1);
    finish_test();
  end
  // Cuts a hang short.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 2000) begin
      fail_count++;
      finish_test();
    end
  end
endmodule
